// file: dip_pkg.sv
`default_nettype none
package dip_pkg;
  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int LANE_W = 14;           // One sample word
  localparam int SCAN_W = 4 * LANE_W;   // Whole input register
  localparam int ADDR_W = 8;            // Register port address
  localparam int DATA_W = 32;           // Register port data

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00; // Sticky events, write one clears
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h04;   // Interrupt enables
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h08;   // Block control
  localparam logic [ADDR_W-1:0] OFS_STATE = 8'h0c;  // Live state, read only

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int EV_PARITY = 0;          // Parity mismatch seen
  localparam int EV_LOCK_GAIN = 1;       // Lock indicator rose
  localparam int EV_LOCK_LOSS = 2;       // Lock indicator fell
  localparam int EV_W = 3;
  localparam int CTRL_PAR_EN = 0;        // Parity check enable
  localparam int ST_LOCK = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_SCAN = 2;
  localparam int ST_BYPASS = 3;
  localparam logic [EV_W-1:0] MASK_RESET = 3'h0;
  localparam logic [0:0] CTRL_RESET = 1'h1;

  // ------------------------------------------------------------
  // Timing counts, in data-clock periods
  // ------------------------------------------------------------
  localparam logic [5:0] FAULT_HOLD_CNT = 6'h30;  // 48 periods
  localparam int PARITY_LAG = 3;                  // Parity lane lateness
  localparam logic [5:0] LOCK_EDGES = 6'h20;      // Pattern edges to lock

  // Divider limits, in converter clock periods minus one
  localparam logic [1:0] DIV_LIM_BY4 = 2'h1;
  localparam logic [1:0] DIV_LIM_BY8 = 2'h3;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  // Four-level pin reading
  typedef enum logic [1:0] {
    LVL_LOW = 2'h0,
    LVL_RES = 2'h1,
    LVL_OPEN = 2'h2,
    LVL_HIGH = 2'h3
  } dip_level_type;

  // Four sample lanes, offset binary, bit 13 most significant
  typedef struct packed {
    logic [LANE_W-1:0] a;
    logic [LANE_W-1:0] b;
    logic [LANE_W-1:0] c;
    logic [LANE_W-1:0] d;
  } dip_lanes_type;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic write;
    logic read;
  } dip_reg_req_type;
endpackage
`default_nettype wire

// file: dip_outclk_gen.sv
`timescale 1ns/1ps
`default_nettype none
module dip_outclk_gen
  import dip_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ratio_pick,
  input wire logic lag_on,
  output logic data_en,
  output logic clk_out
);
  // ------------------------------------------------------------
  // Divider
  // ------------------------------------------------------------
  logic [1:0] cnt;      // Converter clock periods into data period
  logic [1:0] next_cnt;
  logic [1:0] limit;    // Last count of the period
  logic raw;            // Undelayed data clock level
  logic d1;             // One stage of output delay
  logic d2;             // Extra converter clock period of delay

  assign limit = ratio_pick ? DIV_LIM_BY8 : DIV_LIM_BY4;
  // Greater-or-equal so a ratio change mid-period cannot overrun
  assign data_en = (cnt >= limit);
  assign next_cnt = data_en ? 2'h0 : cnt + 2'h1;
  assign raw = ratio_pick ? ~cnt[1] : ~cnt[0];

  // Count converter clock periods
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt <= 2'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // Output delay line
  always_ff @(posedge core_clk) begin
    if (rst) begin
      d1 <= 1'b0;
      d2 <= 1'b0;
    end else begin
      d1 <= raw;
      d2 <= d1;
    end
  end

  assign clk_out = lag_on ? d2 : d1;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_div_by4: assert property (@(posedge core_clk) disable iff (rst)
    (data_en && !ratio_pick) ##1 !ratio_pick[*2] |-> data_en)
    else $error("data enable period wrong for divide by four");
  a_div_by8_gap: assert property (@(posedge core_clk) disable iff (rst)
    (data_en && ratio_pick) ##1 ratio_pick[*4] |-> !$past(data_en) && data_en)
    else $error("data enable period wrong for divide by eight");
  a_lag_delay: assert property (@(posedge core_clk) disable iff (rst)
    lag_on && $past(!rst, 2) |-> clk_out == $past(raw, 2))
    else $error("extra lag not one converter period");
  c_ratio_eight: cover property (@(posedge core_clk) disable iff (rst)
    ratio_pick && data_en ##4 data_en);
endmodule
`default_nettype wire

// file: dip_input_port.sv
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Scan low: shared output shows lock
// - Scan high: input register shifts out
// - Parity mismatch raises fault for 48 periods
// - Fault may pulse spuriously before lock
// - Data clock is update rate over 8 or 4
// - Bypass high disables the DLL
// - Bypassed: extra lag adds one clock period
// - Not bypassed: both pins select DLL setup
// - Mixing input toggles half-rate modulation
// - Lanes carry 14-bit offset binary samples
// - Whitening lane XORs all lanes, one late
module dip_input_port
  import dip_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire dip_pkg::dip_lanes_type lanes_in,
  input wire logic parity_lane,
  input wire logic whitening_lane,
  input wire logic timing_pattern_lane,
  input wire logic scan_shift_ctl,
  input wire logic outclk_ratio_pick,
  input wire dip_pkg::dip_level_type dll_bypass_pin,
  input wire dip_pkg::dip_level_type extra_lag_pin,
  input wire logic half_rate_mixing_on,
  input wire dip_pkg::dip_reg_req_type reg_req,
  output logic [dip_pkg::DATA_W-1:0] reg_rdata,
  output logic irq,
  output logic lock_scan_out,
  output logic parity_fault_flag,
  output logic source_facing_clock_out,
  output dip_pkg::dip_lanes_type sample_out,
  output logic [3:0] dll_config
);
  import dip_pkg::*;

  // ------------------------------------------------------------
  // Data clock and mode pins
  // ------------------------------------------------------------
  logic data_en;     // One pulse per data-clock period
  logic bypass;      // DLL disabled
  logic lag_on;      // Extra converter period wanted

  assign bypass = (dll_bypass_pin == LVL_HIGH);
  assign lag_on = bypass && (extra_lag_pin == LVL_HIGH);
  // both four-level pins form the setup when not bypassed; bypass forces it to zero
  assign dll_config = bypass ? 4'h0 : {dll_bypass_pin, extra_lag_pin};

  dip_outclk_gen u_outclk (
    .core_clk(core_clk),
    .rst(rst),
    .ratio_pick(outclk_ratio_pick),
    .lag_on(lag_on),
    .data_en(data_en),
    .clk_out(source_facing_clock_out)
  );

  // ------------------------------------------------------------
  // Lock model
  // ------------------------------------------------------------
  logic [5:0] edge_cnt;     // Pattern transitions seen
  logic pattern_prev;       // Pattern lane at last data period
  logic dll_lock;           // Lock indicator
  logic lock_prev;          // For lock edge events

  assign dll_lock = (edge_cnt == LOCK_EDGES);

  // Lock builds on pattern activity; a dead pattern never locks
  always_ff @(posedge core_clk) begin
    if (rst || bypass) begin
      edge_cnt <= 6'h0;
      pattern_prev <= 1'b0;
    end else if (data_en) begin
      pattern_prev <= timing_pattern_lane;
      if (timing_pattern_lane != pattern_prev && !dll_lock) begin
        edge_cnt <= edge_cnt + 6'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Input register and whitening
  // ------------------------------------------------------------
  logic [SCAN_W-1:0] raw_prev;   // Last raw words, waiting for whitening
  logic [SCAN_W-1:0] in_reg;     // Input register, also scan chain
  logic [SCAN_W-1:0] whitened;   // Raw words after whitening

  // whitening bit belongs to previous words
  assign whitened = raw_prev ^ {SCAN_W{whitening_lane}};

  // Capture normally, shift while scanning
  always_ff @(posedge core_clk) begin
    if (rst) begin
      raw_prev <= '0;
      in_reg <= '0;
    end else if (data_en) begin
      raw_prev <= lanes_in;
      if (scan_shift_ctl) begin
        in_reg <= {in_reg[SCAN_W-2:0], 1'b0};
      end else begin
        in_reg <= whitened;
      end
    end
  end

  assign lock_scan_out = scan_shift_ctl ? in_reg[SCAN_W-1] : dll_lock;

  // ------------------------------------------------------------
  // Sample output and half-rate mixing
  // ------------------------------------------------------------
  dip_lanes_type held;       // Input register viewed as lanes
  dip_lanes_type mixed;      // After half-rate modulation

  assign held = in_reg;
  assign mixed.a = held.a;
  assign mixed.b = half_rate_mixing_on ? ~held.b : held.b;
  assign mixed.c = held.c;
  assign mixed.d = half_rate_mixing_on ? ~held.d : held.d;

  // Output stays still during scan so the DAC does not see the chain
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sample_out <= '0;
    end else if (!scan_shift_ctl) begin
      sample_out <= mixed;
    end
  end

  // ------------------------------------------------------------
  // Parity check
  // ------------------------------------------------------------
  logic [PARITY_LAG-1:0] par_pipe;  // Parity of words, aged per period
  logic par_en;                     // Check enabled by software
  logic par_hit;                    // Mismatch this period
  logic [5:0] hold_cnt;             // Fault flag hold time left

  // compare against words three periods old
  assign par_hit = data_en && par_en && (parity_lane != par_pipe[PARITY_LAG-1]);
  assign parity_fault_flag = (hold_cnt != 6'h0);

  // Age the computed parity with the data clock
  always_ff @(posedge core_clk) begin
    if (rst) begin
      par_pipe <= '0;
    end else if (data_en) begin
      par_pipe <= {par_pipe[PARITY_LAG-2:0], ^lanes_in};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold_cnt <= 6'h0;
    end else if (par_hit) begin
      hold_cnt <= FAULT_HOLD_CNT;
    end else if (data_en && parity_fault_flag) begin
      hold_cnt <= hold_cnt - 6'h1;
    end
  end

  // ------------------------------------------------------------
  // Register port and interrupt
  // ------------------------------------------------------------
  logic [EV_W-1:0] status;    // Sticky events
  logic [EV_W-1:0] mask;      // Interrupt enables
  logic [0:0] ctrl;           // Control bits
  logic [EV_W-1:0] events;    // Events this cycle
  logic [EV_W-1:0] wr_clear;  // Write-one-to-clear bits
  logic [DATA_W-1:0] rd_mux;  // Read selection
  logic sel_status;
  logic sel_mask;
  logic sel_ctrl;
  logic sel_state;

  assign sel_status = (reg_req.addr == OFS_STATUS);
  assign sel_mask = (reg_req.addr == OFS_MASK);
  assign sel_ctrl = (reg_req.addr == OFS_CTRL);
  assign sel_state = (reg_req.addr == OFS_STATE);
  assign par_en = ctrl[CTRL_PAR_EN];

  assign events[EV_PARITY] = par_hit;
  assign events[EV_LOCK_GAIN] = dll_lock && !lock_prev;
  assign events[EV_LOCK_LOSS] = !dll_lock && lock_prev;
  assign wr_clear = (reg_req.write && sel_status) ? reg_req.wdata[EV_W-1:0] : '0;
  assign irq = |(status & mask);

  // Unmapped addresses read as zero
  assign rd_mux = sel_status ? {{(DATA_W-EV_W){1'b0}}, status} :
                  sel_mask ? {{(DATA_W-EV_W){1'b0}}, mask} :
                  sel_ctrl ? {{(DATA_W-1){1'b0}}, ctrl} :
                  sel_state ? {28'h0, bypass, scan_shift_ctl, parity_fault_flag, dll_lock} :
                  '0;

  // Set wins over a same-cycle clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status <= '0;
      lock_prev <= 1'b0;
    end else begin
      status <= (status & ~wr_clear) | events;
      lock_prev <= dll_lock;
    end
  end

  // Writable registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask <= MASK_RESET;
      ctrl <= CTRL_RESET;
    end else if (reg_req.write) begin
      if (sel_mask) begin
        mask <= reg_req.wdata[EV_W-1:0];
      end else if (sel_ctrl) begin
        ctrl <= reg_req.wdata[0:0];
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_req.read ? rd_mux : '0;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_lock_on_pin: assert property (@(posedge core_clk) disable iff (rst)
    !scan_shift_ctl |-> lock_scan_out == dll_lock)
    else $error("shared pin does not show lock");
  a_scan_shift_out: assert property (@(posedge core_clk) disable iff (rst)
    scan_shift_ctl && data_en ##1 scan_shift_ctl |-> lock_scan_out == $past(in_reg[SCAN_W-2]))
    else $error("scan chain did not advance by one bit");
  a_fault_load: assert property (@(posedge core_clk) disable iff (rst)
    par_hit |=> parity_fault_flag && hold_cnt == FAULT_HOLD_CNT)
    else $error("fault hold not loaded with 48");
  a_fault_end: assert property (@(posedge core_clk) disable iff (rst)
    $fell(parity_fault_flag) |-> $past(hold_cnt) == 6'h1 && $past(data_en))
    else $error("fault flag dropped early");
  a_bypass_nolock: assert property (@(posedge core_clk) disable iff (rst)
    bypass |=> !dll_lock)
    else $error("lock shown with DLL bypassed");
  a_dll_setup: assert property (@(posedge core_clk) disable iff (rst)
    !bypass |-> dll_config == {dll_bypass_pin, extra_lag_pin})
    else $error("DLL setup does not follow pins");
  a_mix_invert: assert property (@(posedge core_clk) disable iff (rst)
    !scan_shift_ctl && half_rate_mixing_on |=> sample_out.b == ~$past(held.b)
      && sample_out.a == $past(held.a))
    else $error("half-rate modulation wrong");
  a_whiten_lane: assert property (@(posedge core_clk) disable iff (rst)
    data_en && !scan_shift_ctl |=> in_reg == ($past(raw_prev) ^ {SCAN_W{$past(whitening_lane)}}))
    else $error("whitening not applied to previous words");
  a_parity_pair: assert property (@(posedge core_clk) disable iff (rst)
    data_en ##1 (!data_en)[*1] ##0 1'b1 |-> par_pipe[0] == $past(^lanes_in, 1))
    else $error("parity pipe did not take the words");
  // Set wins, so a same-cycle clear cannot hide the event
  a_irq_level: assert property (@(posedge core_clk) disable iff (rst)
    |(events & mask) && !reg_req.write |=> irq)
    else $error("interrupt not raised");

  // Register port, scan freeze and lock timing
  a_rdata_idle: assert property (@(posedge core_clk) disable iff (rst)
    !reg_req.read |=> reg_rdata == '0)
    else $error("read data left standing");
  a_mask_write: assert property (@(posedge core_clk) disable iff (rst)
    reg_req.write && sel_mask |=> mask == $past(reg_req.wdata[EV_W-1:0]))
    else $error("mask write did not land");
  a_ctrl_write: assert property (@(posedge core_clk) disable iff (rst)
    reg_req.write && sel_ctrl |=> ctrl == $past(reg_req.wdata[0:0]))
    else $error("control write did not land");
  a_scan_freeze: assert property (@(posedge core_clk) disable iff (rst)
    scan_shift_ctl |=> $stable(sample_out))
    else $error("sample output moved during scan");
  a_lock_on_beat: assert property (@(posedge core_clk) disable iff (rst)
    $rose(dll_lock) |-> $past(data_en))
    else $error("lock rose off a data period");
  c_fault_seen: cover property (@(posedge core_clk) disable iff (rst) $rose(parity_fault_flag));
  c_lock_gain: cover property (@(posedge core_clk) disable iff (rst) $rose(dll_lock));
  c_scan_run: cover property (@(posedge core_clk) disable iff (rst)
    scan_shift_ctl && data_en ##2 scan_shift_ctl && data_en);
  c_irq_clear: cover property (@(posedge core_clk) disable iff (rst) $fell(irq));
endmodule
`default_nettype wire

// file: dip_source_model.sv
`timescale 1ns/1ps
`default_nettype none
// Sample source on the far side of the input port
module dip_source_model
  import dip_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic data_clk,
  input wire logic [dip_pkg::SCAN_W-1:0] word,
  input wire logic whiten,
  input wire logic bad_par,
  input wire logic pat_on,
  output dip_pkg::dip_lanes_type lanes,
  output logic par,
  output logic wl,
  output logic pat
);
  // ------------------------------------------------------------
  // Period tracking
  // ------------------------------------------------------------
  logic clk_d;       // Data clock one cycle ago
  logic wh_d;        // Whitening bit of the current word
  logic [2:0] par_h; // Parities of the last three words
  logic [7:0] lfsr;  // Pattern generator, never all zero
  wire logic step = data_clk & ~clk_d; // Start of a data period

  // Everything but clk_d moves once a period; parity trails the lanes by three words, whitening by one
  always_ff @(posedge core_clk) begin
    clk_d <= data_clk;
    if (rst) begin
      lanes <= '0;
      par <= 1'b0;
      par_h <= 3'h0;
      wh_d <= 1'b0;
      wl <= 1'b0;
      lfsr <= 8'h01;
      pat <= 1'b0;
    end else if (step) begin
      lanes <= dip_lanes_type'(word);
      par_h <= {par_h[1:0], ^word};
      par <= par_h[2] ^ bad_par;
      wh_d <= whiten;
      wl <= wh_d;
      lfsr <= pat_on ? {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]} : lfsr;
      pat <= pat_on & lfsr[0];
    end
  end
endmodule
`default_nettype wire

// file: dip_input_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dip_input_port_bench;
  import dip_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic scan_shift_ctl = 1'b0;
  logic outclk_ratio_pick = 1'b0;
  dip_level_type dll_bypass_pin = LVL_LOW;
  dip_level_type extra_lag_pin = LVL_LOW;
  logic half_rate_mixing_on = 1'b0;
  dip_reg_req_type reg_req = '0;
  logic [SCAN_W-1:0] word = '0;
  logic whiten = 1'b0;
  logic bad_par = 1'b0;
  logic pat_on = 1'b0;
  dip_lanes_type lanes_in;
  logic parity_lane;
  logic whitening_lane;
  logic timing_pattern_lane;
  logic [DATA_W-1:0] reg_rdata;
  logic irq;
  logic lock_scan_out;
  logic parity_fault_flag;
  logic source_facing_clock_out;
  dip_lanes_type sample_out;
  logic [3:0] dll_config;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;
  logic prev;
  logic v [4];                  // Clock shape over one period
  logic [SCAN_W-1:0] w;
  logic [DATA_W-1:0] rd_q [$];  // Expected read data, oldest first
  logic rd_pend = 1'b0;
  wire logic [1:0] watch = {parity_fault_flag, lock_scan_out};
  localparam logic [SCAN_W-1:0] MIX_MASK = {14'h0, 14'h3fff, 14'h0, 14'h3fff};

  always #5 core_clk = ~core_clk;

  dip_input_port u_dip_input_port (.core_clk(core_clk), .rst(rst), .lanes_in(lanes_in),
    .parity_lane(parity_lane), .whitening_lane(whitening_lane),
    .timing_pattern_lane(timing_pattern_lane), .scan_shift_ctl(scan_shift_ctl),
    .outclk_ratio_pick(outclk_ratio_pick), .dll_bypass_pin(dll_bypass_pin),
    .extra_lag_pin(extra_lag_pin), .half_rate_mixing_on(half_rate_mixing_on),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .irq(irq), .lock_scan_out(lock_scan_out),
    .parity_fault_flag(parity_fault_flag), .source_facing_clock_out(source_facing_clock_out),
    .sample_out(sample_out), .dll_config(dll_config));

  dip_source_model u_dip_source_model (.core_clk(core_clk), .rst(rst),
    .data_clk(source_facing_clock_out), .word(word), .whiten(whiten), .bad_par(bad_par),
    .pat_on(pat_on), .lanes(lanes_in), .par(parity_lane), .wl(whitening_lane),
    .pat(timing_pattern_lane));

  // ------------------------------------------------------------
  // Checking
  // ------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] e, input logic [63:0] a);
    comparisons++;
    if (e !== a) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, a, e);
    end
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (rd_pend) begin
      chk(64'(rd_q.pop_front()), 64'(reg_rdata));
    end
    rd_pend <= reg_req.read;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge core_clk);
    reg_req <= '0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    rd_q.push_back(e);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: '0, write: 1'b0, read: 1'b1};
    @(posedge core_clk);
    reg_req <= '0;
  endtask

  // Bounded wait for one watched output to reach a level
  task automatic wait_lvl(input int s, input logic lv, input int lim);
    int i;
    i = 0;
    while (watch[s] !== lv && i < lim) begin
      @(negedge core_clk);
      i++;
    end
    if (watch[s] !== lv) begin
      miscompares++;
      $display("[ERR] %0t wait ran out", $time);
      summarize();
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h9807));
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    // Reset values, read-only and unmapped places
    rd(OFS_STATUS, 32'h0);
    rd(OFS_MASK, 32'(MASK_RESET));
    rd(OFS_CTRL, 32'(CTRL_RESET));
    wr(OFS_MASK, 32'h7);
    wr(OFS_STATE, 32'hf);
    wr(8'h10, 32'hffffffff);
    rd(OFS_MASK, 32'h7);
    rd(OFS_STATE, 32'h0);
    rd(8'h10, 32'h0);
    $display("test registers done");
    pat_on <= 1'b1;
    wait_lvl(0, 1'b1, 1000);
    rd(OFS_STATE, 32'h1);
    rd(OFS_STATUS, 32'h2);
    chk(1, irq);
    wr(OFS_STATUS, 32'h7);
    @(negedge core_clk);
    chk(0, irq);
    for (int b = 0; b < 3; b++) begin
      for (int l = 0; l < 4; l++) begin
        @(posedge core_clk);
        dll_bypass_pin <= dip_level_type'(b);
        extra_lag_pin <= dip_level_type'(l);
        @(negedge core_clk);
        chk(64'(b * 4 + l), 64'(dll_config));
      end
    end
    @(posedge core_clk);
    dll_bypass_pin <= LVL_LOW;
    extra_lag_pin <= LVL_LOW;
    $display("test lock done");
    // Boundary word first, then random words with whitening and mixing
    for (int k = 0; k < 4; k++) begin
      w = (k == 0) ? {14'h2000, 14'h3fff, 14'h0000, 14'h1fff} : SCAN_W'({$urandom, $urandom});
      @(posedge core_clk);
      word <= w;
      whiten <= k[0];
      half_rate_mixing_on <= k[1];
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      chk(w ^ {SCAN_W{k[0]}} ^ (k[1] ? MIX_MASK : '0), sample_out);
    end
    $display("test data done");
    wr(OFS_STATUS, 32'h7);
    wr(OFS_MASK, 32'h1);
    chk(1, lock_scan_out);
    @(posedge core_clk);
    bad_par <= 1'b1;
    wait_lvl(1, 1'b1, 40);
    @(posedge core_clk);
    bad_par <= 1'b0;
    n = 0;
    while (parity_fault_flag === 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    chk(1, n >= 96 && n <= 110);
    chk(1, irq);
    rd(OFS_STATUS, 32'h1);
    wr(OFS_STATUS, 32'h1);
    wr(OFS_CTRL, 32'h0);
    @(posedge core_clk);
    bad_par <= 1'b1;
    repeat (8) @(posedge core_clk);
    bad_par <= 1'b0;
    repeat (30) @(posedge core_clk);
    chk(0, parity_fault_flag);
    rd(OFS_STATUS, 32'h0);
    wr(OFS_CTRL, 32'h1);
    $display("test parity done");
    for (int r = 0; r < 2; r++) begin
      @(posedge core_clk);
      outclk_ratio_pick <= r[0];
      repeat (8) @(posedge core_clk);
      @(negedge core_clk);
      prev = source_facing_clock_out;
      n = 0;
      repeat (80) begin
        @(negedge core_clk);
        n += int'(!prev && source_facing_clock_out);
        prev = source_facing_clock_out;
      end
      chk(r ? 20 : 40, n);
    end
    $display("test clock done");
    @(posedge core_clk);
    dll_bypass_pin <= LVL_HIGH;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk(0, lock_scan_out);
    chk(0, dll_config);
    rd(OFS_STATE, 32'h8);
    rd(OFS_STATUS, 32'h4);
    repeat (8) begin
      @(negedge core_clk);
      v[cyc % 4] = source_facing_clock_out;
    end
    @(posedge core_clk);
    extra_lag_pin <= LVL_HIGH;
    repeat (8) @(posedge core_clk);
    repeat (8) begin
      @(negedge core_clk);
      chk(v[(cyc + 3) % 4], source_facing_clock_out);
    end
    @(posedge core_clk);
    dll_bypass_pin <= LVL_LOW;
    extra_lag_pin <= LVL_LOW;
    outclk_ratio_pick <= 1'b0;
    word <= {14{4'h5}};
    whiten <= 1'b0;
    half_rate_mixing_on <= 1'b0;
    $display("test bypass done");
    // Alternating word makes the serial stream toggle every period
    repeat (12) @(posedge core_clk);
    w = SCAN_W'({$urandom, $urandom});
    scan_shift_ctl <= 1'b1;
    word <= w;
    @(negedge core_clk);
    chk(0, lock_scan_out);
    prev = lock_scan_out;
    n = 0;
    repeat (40) begin
      @(negedge core_clk);
      n += int'(prev !== lock_scan_out);
      prev = lock_scan_out;
    end
    chk(1, n >= 19 && n <= 21);
    repeat (120) @(negedge core_clk);
    chk(0, lock_scan_out);
    chk({14{4'h5}}, sample_out);
    @(posedge core_clk);
    scan_shift_ctl <= 1'b0;
    wait_lvl(0, 1'b1, 1000);
    // Register refills on the next data period, output one edge later
    repeat (4) @(negedge core_clk);
    chk(w, sample_out);
    $display("test scan done");
    repeat (2) @(posedge core_clk);
    summarize();
  end
endmodule
`default_nettype wire
